// ### logic/periodic_timer.sv
// 10-bit periodic timer with APB registers, compare, capture, PWM and pulse
// assumes pins are synchronous to pclk and sub_clk_tick is a one-cycle strobe
`timescale 1ns/100ps
`default_nettype none
module periodic_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_pin,
    input wire logic capture_input_pin,
    input wire logic sub_clk_tick,
    output logic timer_output_pin,
    output logic timer_output_oe,
    output logic match_a_flag,
    output logic match_p_flag
);
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [9:0] count;
    logic [9:0] compare_a_value;
    logic [9:0] compare_p_value;
    logic en_q;
    logic out_state;
    logic tick4;
    logic tick16;
    logic tick64;

    edge_if ext_edges ();
    edge_if cap_edges ();

    pin_edge #(.IDLE_LEVEL(1'b0)) u_ext_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_clock_pin),
        .edges(ext_edges)
    );

    pin_edge #(.IDLE_LEVEL(1'b0)) u_cap_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(capture_input_pin),
        .edges(cap_edges)
    );

    clock_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .tick4(tick4),
        .tick16(tick16),
        .tick64(tick64)
    );

    // register fields
    wire pause_ctl = ctl0[timer_pkg::CTL0_PAUSE];
    wire [2:0] count_clk_sel = ctl0[timer_pkg::CTL0_CKSEL +: 3];
    wire counter_enable_bit = ctl0[timer_pkg::CTL0_EN];
    wire [1:0] op_mode_field = ctl1[timer_pkg::CTL1_MODE +: 2];
    wire [1:0] pin_function_field = ctl1[timer_pkg::CTL1_IO +: 2];
    wire out_level_ctl = ctl1[timer_pkg::CTL1_OC];
    wire out_invert = ctl1[timer_pkg::CTL1_POL];
    wire capture_source_sel = ctl1[timer_pkg::CTL1_CAPTS];
    wire clear_select = ctl1[timer_pkg::CTL1_CCLR];

    // APB decode
    wire acc = psel & penable & ~pready;
    wire wr = psel & penable & pready & pwrite;
    wire sel_ctl0 = paddr == timer_pkg::OFS_CTL0;
    wire sel_ctl1 = paddr == timer_pkg::OFS_CTL1;
    wire sel_cnt_lo = paddr == timer_pkg::OFS_CNT_LO;
    wire sel_cnt_hi = paddr == timer_pkg::OFS_CNT_HI;
    wire sel_a_lo = paddr == timer_pkg::OFS_CMPA_LO;
    wire sel_a_hi = paddr == timer_pkg::OFS_CMPA_HI;
    wire sel_p_lo = paddr == timer_pkg::OFS_PER_LO;
    wire sel_p_hi = paddr == timer_pkg::OFS_PER_HI;
    wire hit_any = sel_ctl0 | sel_ctl1 | sel_cnt_lo | sel_cnt_hi
        | sel_a_lo | sel_a_hi | sel_p_lo | sel_p_hi;
    wire [7:0] rd_byte =
        sel_ctl0 ? ctl0 :
        sel_ctl1 ? ctl1 :
        sel_cnt_lo ? count[7:0] :
        sel_cnt_hi ? {6'h00, count[9:8]} :
        sel_a_lo ? compare_a_value[7:0] :
        sel_a_hi ? {6'h00, compare_a_value[9:8]} :
        sel_p_lo ? compare_p_value[7:0] :
        sel_p_hi ? {6'h00, compare_p_value[9:8]} : 8'h00;

    // mode decode
    wire mode_cmp = op_mode_field == timer_pkg::MODE_CMP;
    wire mode_cap = op_mode_field == timer_pkg::MODE_CAP;
    wire mode_pwm = op_mode_field == timer_pkg::MODE_PWM;
    wire mode_tmr = op_mode_field == timer_pkg::MODE_TMR;
    wire cmp_like = mode_cmp | mode_tmr;
    wire pulse_mode = mode_pwm & (pin_function_field == timer_pkg::IO_PULSE);
    wire clr_by_a = cmp_like & clear_select;

    // clock source selection
    wire tick =
        (count_clk_sel == timer_pkg::CK_SYS4) ? tick4 :
        (count_clk_sel == timer_pkg::CK_SYS) ? 1'b1 :
        (count_clk_sel == timer_pkg::CK_H16) ? tick16 :
        (count_clk_sel == timer_pkg::CK_H64) ? tick64 :
        (count_clk_sel == timer_pkg::CK_SUB0) ? sub_clk_tick :
        (count_clk_sel == timer_pkg::CK_SUB1) ? sub_clk_tick :
        (count_clk_sel == timer_pkg::CK_EXT_R) ? ext_edges.rise : ext_edges.fall;

    // counter core
    wire en_rise = counter_enable_bit & ~en_q;
    wire run = counter_enable_bit & ~pause_ctl & ~en_rise;
    wire step = run & tick;
    wire [9:0] inc = count + 10'h001;
    // compare P value zero matches on wrap, giving overflow clearing
    wire hit_a = step & (inc == compare_a_value) & (compare_a_value != 10'h000);
    wire hit_p = step & (inc == compare_p_value);
    wire p_evt = hit_p & ~clr_by_a & ~pulse_mode;
    wire ctr_clear = (hit_a & clr_by_a) | p_evt;
    wire [9:0] next_count = en_rise ? 10'h000 : step ? (ctr_clear ? 10'h000 : inc) : count;

    // capture
    wire src_rise = capture_source_sel ? ext_edges.rise : cap_edges.rise;
    wire src_fall = capture_source_sel ? ext_edges.fall : cap_edges.fall;
    wire cap_evt = mode_cap & counter_enable_bit & (
        ((pin_function_field == timer_pkg::CAP_RISE) & src_rise)
        | ((pin_function_field == timer_pkg::CAP_FALL) & src_fall)
        | ((pin_function_field == timer_pkg::CAP_BOTH) & (src_rise | src_fall)));
    wire a_evt = mode_cap ? cap_evt : hit_a;

    // enable bit: in pulse mode the pin trigger sets it and compare A clears it
    wire hw_set_en = pulse_mode & ext_edges.rise;
    wire hw_clr_en = pulse_mode & hit_a;
    wire [7:0] sw_ctl0 = (wr & sel_ctl0) ? (pwdata[7:0] & timer_pkg::CTL0_MASK) : ctl0;
    wire next_en = hw_set_en | (sw_ctl0[timer_pkg::CTL0_EN] & ~hw_clr_en);
    wire [7:0] next_ctl0 = {sw_ctl0[7:4], next_en, 3'h0};

    // output waveform
    wire cmp_action =
        (pin_function_field == timer_pkg::IO_LOW) ? 1'b0 :
        (pin_function_field == timer_pkg::IO_HIGH) ? 1'b1 :
        (pin_function_field == timer_pkg::IO_TOGGLE) ? ~out_state : out_state;
    wire pwm_level = (counter_enable_bit & (count < compare_a_value))
        ? out_level_ctl : ~out_level_ctl;
    wire pwm_out =
        (pin_function_field == timer_pkg::IO_INACT) ? ~out_level_ctl :
        (pin_function_field == timer_pkg::IO_ACT) ? out_level_ctl :
        (pin_function_field == timer_pkg::IO_PWM) ? pwm_level :
        (counter_enable_bit ? out_level_ctl : ~out_level_ctl);
    wire next_out =
        (mode_cmp & en_rise) ? out_level_ctl :
        (mode_cmp & hit_a) ? cmp_action :
        mode_pwm ? pwm_out : out_state;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc;
            pslverr <= acc & ~hit_any;
            prdata <= (acc & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0 <= timer_pkg::CTL0_RESET;
            ctl1 <= timer_pkg::CTL1_RESET;
            en_q <= 1'b0;
        end else begin
            ctl0 <= next_ctl0;
            ctl1 <= (wr & sel_ctl1) ? pwdata[7:0] : ctl1;
            en_q <= counter_enable_bit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_value <= timer_pkg::VAL_RESET;
            compare_p_value <= timer_pkg::VAL_RESET;
        end else begin
            if (cap_evt) begin
                compare_a_value <= count;
            end else if (wr & sel_a_lo) begin
                compare_a_value <= {compare_a_value[9:8], pwdata[7:0]};
            end else if (wr & sel_a_hi) begin
                compare_a_value <= {pwdata[1:0], compare_a_value[7:0]};
            end
            if (wr & sel_p_lo) begin
                compare_p_value <= {compare_p_value[9:8], pwdata[7:0]};
            end else if (wr & sel_p_hi) begin
                compare_p_value <= {pwdata[1:0], compare_p_value[7:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= timer_pkg::VAL_RESET;
            out_state <= 1'b0;
            timer_output_pin <= 1'b0;
            timer_output_oe <= 1'b0;
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            count <= next_count;
            out_state <= next_out;
            timer_output_pin <= next_out ^ out_invert;
            timer_output_oe <= mode_cmp | mode_pwm;
            match_a_flag <= a_evt;
            match_p_flag <= p_evt;
        end
    end

    AST_ENABLE_CLEARS: assert property (
        @(posedge pclk) disable iff (!presetn)
        en_rise |=> count == 10'h000)
        else $error("counter not zero after enable rise");

    AST_PAUSE_HOLDS: assert property (
        @(posedge pclk) disable iff (!presetn)
        counter_enable_bit & en_q & pause_ctl |=> count == $past(count))
        else $error("counter moved while paused");

    AST_OFF_HOLDS: assert property (
        @(posedge pclk) disable iff (!presetn)
        !counter_enable_bit ##1 !counter_enable_bit |-> $stable(count))
        else $error("counter moved while disabled");

    AST_STEP_ONE: assert property (
        @(posedge pclk) disable iff (!presetn)
        step & !ctr_clear |=> count == $past(count) + 10'h001)
        else $error("counter did not step by one");

    AST_INIT_LEVEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        en_rise & mode_cmp |=> timer_output_pin == $past(out_level_ctl ^ out_invert))
        else $error("output not at initial level after enable rise");

    AST_CLEAR_ON_A: assert property (
        @(posedge pclk) disable iff (!presetn)
        hit_a & clr_by_a |=> count == 10'h000 && !match_p_flag)
        else $error("compare A clear wrong");

    AST_OVERFLOW_ZERO_P: assert property (
        @(posedge pclk) disable iff (!presetn)
        step & cmp_like & !clear_select & count == 10'h3FF & compare_p_value != 10'h000
        |=> !match_p_flag)
        else $error("overflow flagged with nonzero compare P");

    AST_TIMER_NO_OE: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_tmr |=> !timer_output_oe)
        else $error("pin driven in timer mode");

    AST_CAPTURE: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_evt |=> compare_a_value == $past(count) && match_a_flag)
        else $error("capture did not store the count");

    AST_RO_COUNT: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc & !pwrite & sel_cnt_hi |=> prdata == {24'h00_0000, 6'h00, $past(count[9:8])})
        else $error("count high byte read wrong");

    AST_P_CLEARS: assert property (
        @(posedge pclk) disable iff (!presetn)
        p_evt |=> count == 10'h000 && match_p_flag)
        else $error("compare P match did not clear");

    AST_CMP_HIGH: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_cmp & hit_a & (pin_function_field == timer_pkg::IO_HIGH)
        |=> timer_output_pin != $past(out_invert))
        else $error("compare A match did not raise output");

    AST_SAME_LEVEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_cmp & hit_a & (cmp_action == out_state) & $stable(out_invert)
        |=> $stable(timer_output_pin))
        else $error("output moved on equal level action");

    AST_FORCED_ACTIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_pwm & (pin_function_field == timer_pkg::IO_ACT)
        |=> out_state == $past(out_level_ctl))
        else $error("forced active level not held");

    AST_FORCED_INACTIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_pwm & (pin_function_field == timer_pkg::IO_INACT)
        |=> timer_output_pin == ($past(out_level_ctl) ~^ $past(out_invert)))
        else $error("forced inactive level wrong");

    AST_PULSE_STOPS: assert property (
        @(posedge pclk) disable iff (!presetn)
        pulse_mode & hit_a & !hw_set_en |=> !counter_enable_bit)
        else $error("single pulse did not end");

    AST_PWM_ACTIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_pwm & (pin_function_field == timer_pkg::IO_PWM) & counter_enable_bit
        & (count < compare_a_value) |=> out_state == $past(out_level_ctl))
        else $error("PWM not active below compare A");

    AST_CAP_FROM_EXT: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_cap & counter_enable_bit & capture_source_sel
        & (pin_function_field == timer_pkg::CAP_RISE) & ext_edges.rise |=> match_a_flag)
        else $error("capture from clock pin missed");

    AST_COUNT_READ_ONLY: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr & sel_cnt_lo & !step & !en_rise |=> $stable(count))
        else $error("count register took a write");

    AST_WRITE_CMP_A: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr & sel_a_lo & !cap_evt |=> compare_a_value[7:0] == $past(pwdata[7:0]))
        else $error("compare A low byte not written");
endmodule : periodic_timer
`default_nettype wire

// ### include/timer_pkg.sv
// constants for the 10-bit periodic timer: register offsets, fields, codes
// assumes a 32-bit APB slave with byte offsets; no other package is needed
package timer_pkg;
    localparam int CNT_W = 10;
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CMPA_LO = 8'h10;
    localparam logic [7:0] OFS_CMPA_HI = 8'h14;
    localparam logic [7:0] OFS_PER_LO = 8'h18;
    localparam logic [7:0] OFS_PER_HI = 8'h1C;
    // control 0 fields
    localparam int CTL0_PAUSE = 7;
    localparam int CTL0_CKSEL = 4;
    localparam int CTL0_EN = 3;
    localparam logic [7:0] CTL0_MASK = 8'hF8;
    // control 1 fields
    localparam int CTL1_MODE = 6;
    localparam int CTL1_IO = 4;
    localparam int CTL1_OC = 3;
    localparam int CTL1_POL = 2;
    localparam int CTL1_CAPTS = 1;
    localparam int CTL1_CCLR = 0;
    localparam logic [7:0] CTL0_RESET = 8'h00;
    localparam logic [7:0] CTL1_RESET = 8'h00;
    localparam logic [9:0] VAL_RESET = 10'h000;
    // operating modes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    // pin function codes per mode
    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
    localparam logic [1:0] IO_INACT = 2'h0;
    localparam logic [1:0] IO_ACT = 2'h1;
    localparam logic [1:0] IO_PWM = 2'h2;
    localparam logic [1:0] IO_PULSE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;
    // clock select codes
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB0 = 3'h4;
    localparam logic [2:0] CK_SUB1 = 3'h5;
    localparam logic [2:0] CK_EXT_R = 3'h6;
    localparam logic [2:0] CK_EXT_F = 3'h7;
    // prescaler divide ratios
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0F;
    localparam logic [5:0] DIV64_MASK = 6'h3F;
endpackage : timer_pkg

// ### include/edge_if.sv
// edge pulses from a pin edge detector to the timer core
// assumes both ends run on pclk
`timescale 1ns/100ps
`default_nettype none
interface edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface : edge_if
`default_nettype wire

// ### logic/pin_edge.sv
// edge detector for a pin already synchronous to pclk
// assumes the pin is sampled once per pclk edge
`timescale 1ns/100ps
`default_nettype none
module pin_edge #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    edge_if.src edges
);
    logic prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= IDLE_LEVEL;
        end else begin
            prev <= pin;
        end
    end

    assign edges.rise = pin & ~prev;
    assign edges.fall = ~pin & prev;
endmodule : pin_edge
`default_nettype wire

// ### logic/clock_prescaler.sv
// free-running prescaler giving one-cycle ticks at pclk/4, /16 and /64
// assumes the high clock equals pclk
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick4,
    output logic tick16,
    output logic tick64
);
    logic [5:0] pre;
    logic [5:0] next_pre;

    assign next_pre = pre + 6'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 6'h00;
        end else begin
            pre <= next_pre;
        end
    end

    assign tick4 = (pre & timer_pkg::DIV4_MASK) == timer_pkg::DIV4_MASK;
    assign tick16 = (pre & timer_pkg::DIV16_MASK) == timer_pkg::DIV16_MASK;
    assign tick64 = (pre & timer_pkg::DIV64_MASK) == timer_pkg::DIV64_MASK;
endmodule : clock_prescaler
`default_nettype wire

// ### tb/tb_periodic_timer_10bit_regs.sv
// self-checking bench for the 10-bit periodic timer behind its APB registers
// assumes timer_pkg and the edge interface are compiled before the design
`timescale 1ns/100ps
`default_nettype none
module tb_periodic_timer_10bit_regs;
    typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic err;} note_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ext_clock_pin, capture_input_pin, sub_clk_tick;
    logic timer_output_pin, timer_output_oe, match_a_flag, match_p_flag;
    note_s notes[$];
    int num_errors = 0;
    int total_checks = 0;
    int a_flags = 0;
    logic [31:0] seed = 32'hD81DEC76;

    periodic_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
        .capture_input_pin(capture_input_pin), .sub_clk_tick(sub_clk_tick),
        .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
        .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [31:0] c0(input logic p, input logic [2:0] ck, input logic en);
        return {24'h000000, p, ck, en, 3'h0};
    endfunction : c0

    function automatic logic [31:0] c1(input logic [1:0] m, input logic [1:0] io,
        input logic oc, input logic pol, input logic src, input logic clr);
        return {24'h000000, m, io, oc, pol, src, clr};
    endfunction : c1

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check_bus(input note_s nt, input logic [31:0] got, input logic err);
        total_checks++;
        if (err !== nt.err || (got >= nt.lo && got <= nt.hi) !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t bus got %h err %b", $time, got, err);
        end
    endtask : check_bus

    task automatic check_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t pin got %b want %b", $time, got, exp);
        end
    endtask : check_pin

    task automatic check_num(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            num_errors++;
            $display("MISMATCH %0t count got %0d want %0d", $time, got, exp);
        end
    endtask : check_num

    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t no pready", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: the next setup never reassigns psel in the same step,
        // and the enable-rise clear cycle passes before any counting event
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        notes.push_back({32'h00000000, 32'hFFFFFFFF, 1'b0});
        apb(1'b1, addr, data);
    endtask : wr

    task automatic rd(input logic [7:0] addr, input int lo, input int hi, input logic err);
        notes.push_back({32'(lo), 32'(hi), err});
        apb(1'b0, addr, 32'h00000000);
    endtask : rd

    // returns at the edge where the chosen flag is seen high
    task automatic wait_flag(input logic pf, output int n);
        n = 0;
        @(posedge pclk);
        while ((pf ? match_p_flag : match_a_flag) !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_flag

    // n counting events on the external pin or the sub clock strobe
    task automatic pulses(input logic [2:0] ck, input int n);
        repeat (n) begin
            if (ck[1]) ext_clock_pin <= 1'b1;
            else sub_clk_tick <= 1'b1;
            @(posedge pclk);
            sub_clk_tick <= 1'b0;
            repeat (2) @(posedge pclk);
            ext_clock_pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulses

    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            check_bus(notes.pop_front(), prdata, pslverr);
        end
        if (match_a_flag === 1'b1) a_flags++;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        num_errors++;
        $display("MISMATCH %0t watchdog", $time);
        give_verdict();
    end

    initial begin
        int n, e, hi, a0;
        logic [2:0] ck;
        logic [1:0] io;
        logic oc, pol, src;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, ext_clock_pin, capture_input_pin, sub_clk_tick} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 0, 0, 1'b0);
        rd(8'h20, 0, 0, 1'b1);
        wr(timer_pkg::OFS_CTL0, 32'h000000FF);
        rd(timer_pkg::OFS_CTL0, 32'hF8, 32'hF8, 1'b0);
        wr(timer_pkg::OFS_CNT_LO, 32'h000000FF);
        rd(timer_pkg::OFS_CNT_LO, 0, 0, 1'b0);
        wr(timer_pkg::OFS_CTL0, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            wr(timer_pkg::OFS_CMPA_LO + 8'(8 * (i % 2)), seed);
            wr(timer_pkg::OFS_CMPA_HI + 8'(8 * (i % 2)), seed >> 8);
            rd(timer_pkg::OFS_CMPA_LO + 8'(8 * (i % 2)), seed[7:0], seed[7:0], 1'b0);
            rd(timer_pkg::OFS_CMPA_HI + 8'(8 * (i % 2)), seed[9:8], seed[9:8], 1'b0);
        end
        wr(timer_pkg::OFS_PER_LO, 32'h00000000);
        wr(timer_pkg::OFS_PER_HI, 32'h00000000);
        wr(timer_pkg::OFS_CMPA_HI, 32'h00000000);
        wr(timer_pkg::OFS_CTL1, c1(timer_pkg::MODE_TMR, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        for (int k = 4; k < 8; k++) begin
            ck = 3'(k);
            wr(timer_pkg::OFS_CTL0, c0(1'b0, ck, 1'b1));
            check_pin(timer_output_oe, 1'b0);
            pulses(ck, 5);
            rd(timer_pkg::OFS_CNT_LO, 5, 5, 1'b0);
            wr(timer_pkg::OFS_CTL0, c0(1'b1, ck, 1'b1));
            pulses(ck, 3);
            rd(timer_pkg::OFS_CNT_LO, 5, 5, 1'b0);
            wr(timer_pkg::OFS_CTL0, c0(1'b0, ck, 1'b1));
            pulses(ck, 2);
            rd(timer_pkg::OFS_CNT_LO, 7, 7, 1'b0);
            wr(timer_pkg::OFS_CTL0, c0(1'b0, ck, 1'b0));
            pulses(ck, 4);
            rd(timer_pkg::OFS_CNT_LO, 7, 7, 1'b0);
            wr(timer_pkg::OFS_CTL0, c0(1'b0, ck, 1'b1));
            rd(timer_pkg::OFS_CNT_LO, 0, 0, 1'b0);
            wr(timer_pkg::OFS_CTL0, 32'h00000000);
        end
        for (int k = 0; k < 4; k++) begin
            e = 522 / (k == 0 ? 4 : k == 1 ? 1 : k == 2 ? 16 : 64);
            wr(timer_pkg::OFS_CTL0, c0(1'b0, 3'(k), 1'b1));
            repeat (520) @(posedge pclk);
            wr(timer_pkg::OFS_CTL0, c0(1'b1, 3'(k), 1'b1));
            rd(timer_pkg::OFS_CNT_LO, e % 256 - 4, e % 256 + 4, 1'b0);
            rd(timer_pkg::OFS_CNT_HI, e / 256, e / 256, 1'b0);
            wr(timer_pkg::OFS_CTL0, 32'h00000000);
        end
        wr(timer_pkg::OFS_CMPA_LO, 32'h00000009);
        for (int k = 0; k < 8; k++) begin
            seed = xorshift(seed);
            {oc, io} = 3'(k);
            pol = seed[0];
            wr(timer_pkg::OFS_CTL0, 32'h00000000);
            wr(timer_pkg::OFS_CTL1, c1(timer_pkg::MODE_CMP, io, oc, pol, 1'b0, 1'b1));
            wr(timer_pkg::OFS_CTL0, c0(1'b0, timer_pkg::CK_SYS, 1'b1));
            repeat (3) @(posedge pclk);
            check_pin(timer_output_pin, oc ^ pol);
            check_pin(timer_output_oe, 1'b1);
            wait_flag(1'b0, n);
            repeat (2) @(posedge pclk);
            e = io == 2'h0 ? oc : io == 2'h1 ? 0 : io == 2'h2 ? 1 : !oc;
            check_pin(timer_output_pin, e[0] ^ pol);
            wait_flag(1'b0, n);
            check_num(n + 3, 9);
        end
        wr(timer_pkg::OFS_CTL0, 32'h00000000);
        wr(timer_pkg::OFS_PER_LO, 32'h00000007);
        wr(timer_pkg::OFS_CTL1, c1(timer_pkg::MODE_CMP, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        for (int k = 0; k < 2; k++) begin
            wr(timer_pkg::OFS_CTL0, c0(1'b0, timer_pkg::CK_SYS, 1'b1));
            wait_flag(1'b1, n);
            wait_flag(1'b1, n);
            check_num(n + 1, k == 0 ? 7 : 1024);
            wr(timer_pkg::OFS_CTL0, 32'h00000000);
            wr(timer_pkg::OFS_PER_LO, 32'h00000000);
        end
        wr(timer_pkg::OFS_PER_LO, 32'h00000008);
        wr(timer_pkg::OFS_CMPA_LO, 32'h00000003);
        for (int k = 0; k < 3; k++) begin
            seed = xorshift(seed);
            pol = seed[0];
            wr(timer_pkg::OFS_CTL0, 32'h00000000);
            wr(timer_pkg::OFS_CTL1, c1(timer_pkg::MODE_PWM, 2'(k), 1'b1, pol, 1'b0, 1'b1));
            wr(timer_pkg::OFS_CTL0, c0(1'b0, timer_pkg::CK_SYS, 1'b1));
            wait_flag(1'b1, n);
            wait_flag(1'b1, n);
            check_num(n + 1, 8);
            hi = 0;
            repeat (8) begin
                @(posedge pclk);
                hi += (timer_output_pin === 1'b1);
            end
            e = k == 0 ? 0 : k == 1 ? 8 : 3;
            check_num(hi, pol ? 8 - e : e);
        end
        wr(timer_pkg::OFS_CTL0, 32'h00000000);
        wr(timer_pkg::OFS_CTL1, c1(timer_pkg::MODE_PWM, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0));
        ext_clock_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        check_pin(timer_output_pin, 1'b1);
        wait_flag(1'b0, n);
        repeat (2) @(posedge pclk);
        check_pin(timer_output_pin, 1'b0);
        ext_clock_pin <= 1'b0;
        rd(timer_pkg::OFS_CTL0, 32'h00, 32'h00, 1'b0);
        for (int k = 0; k < 8; k++) begin
            {src, io} = 3'(k);
            wr(timer_pkg::OFS_CTL0, 32'h00000000);
            wr(timer_pkg::OFS_CTL1, c1(timer_pkg::MODE_CAP, io, 1'b0, 1'b0, src, 1'b0));
            wr(timer_pkg::OFS_CTL0, c0(1'b0, timer_pkg::CK_SYS, 1'b1));
            check_pin(timer_output_oe, 1'b0);
            a0 = a_flags;
            for (int j = 0; j < 4; j++) begin
                if (src ^ j[1]) ext_clock_pin <= ~j[0];
                else capture_input_pin <= ~j[0];
                repeat (4) @(posedge pclk);
            end
            e = io == 2'h3 ? 0 : io == 2'h2 ? 2 : 1;
            check_num(a_flags - a0, e);
        end
        give_verdict();
    end
endmodule : tb_periodic_timer_10bit_regs
`default_nettype wire
